//--- include/smh_pkg.sv
// constants and types for the serial port modem handshake block
package smh_pkg;

    localparam int          BYTE_W        = 8;
    localparam logic [3:0]  BITS_PER_CHAR = 4'h8;
    localparam logic [7:0]  LOCAL_DIV     = 8'h10;
    localparam logic [7:0]  LOCAL_HALF    = 8'h08;
    localparam logic        LINE_MARK     = 1'b1;
    localparam int          SYNC_W        = 5;
    localparam int          SYNC_CTS      = 0;
    localparam int          SYNC_DSR      = 1;
    localparam int          SYNC_DCD      = 2;
    localparam int          SYNC_TXCLK    = 3;
    localparam int          SYNC_RXTOG    = 4;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_REQ   = 4'b0010,
        ST_SEND  = 4'b0100,
        ST_DRAIN = 4'b1000
    } smh_tx_state_e;

    typedef struct packed
    {
        logic cts;
        logic dsr;
        logic dcd;
    } smh_modem_s;

endpackage

//--- hdl/smh_sync.sv
// two flip-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
module smh_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstN,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                if (!rstN)
                begin
                    meta_q[i] <= 1'b0;
                    synced[i] <= 1'b0;
                end
                else
                begin
                    meta_q[i] <= async[i];
                    synced[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule

//--- hdl/smh_serial_port.sv
// host end of a modem serial port: handshake, synchronous transmit and receive
`timescale 1ns/1ps
module smh_serial_port
    import smh_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // user side
    input  wire logic              txValid,
    input  wire logic [BYTE_W-1:0] txData,
    output logic                   txReady,
    output logic                   rxValid,
    output logic [BYTE_W-1:0]      rxData,
    input  wire logic              terminalEnable,
    input  wire logic              sendRequest,
    input  wire logic              syncMode,
    input  wire logic              localClkSel,
    output logic                   modemReady,
    output logic                   carrierOn,
    output logic                   sendAllowed,
    // modem side pins
    output logic                   serialTxOut,
    input  wire logic              serialRxIn,
    output logic                   requestToSend,
    input  wire logic              clearToSend,
    input  wire logic              dataSetReady,
    input  wire logic              carrierDetect,
    output logic                   terminalReady,
    input  wire logic              dceTransmitClock,
    input  wire logic              dceReceiveClock,
    output logic                   terminalClockOut
);
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] syncOut;
    smh_modem_s        modem;
    logic              txClkS;
    logic              rxTogS;

    // receive domain signals
    logic              rxRstMeta_q;
    logic              rxRstN_q;
    logic              dcdRxMeta_q;
    logic              dcdRx_q;
    logic [BYTE_W-1:0] rxShift_q;
    logic [3:0]        rxCnt_q;
    logic [BYTE_W-1:0] rxByte_q;
    logic              rxTog_q;

    // system domain signals
    smh_tx_state_e     state_q;
    smh_tx_state_e     state_d;
    logic              rts_q;
    logic              dtr_q;
    logic              txClkPrev_q;
    logic [7:0]        divCnt_q;
    logic              localMode;
    logic              bitEdge;
    logic              gate;
    logic [BYTE_W-1:0] hold_q;
    logic              holdFull_q;
    logic [BYTE_W-1:0] shift_q;
    logic [3:0]        bitCnt_q;
    logic              txd_q;
    logic              tclk_q;
    logic              rxTogPrev_q;
    logic              accept;
    logic              loadNow;

    // handshake inputs and clock echo brought onto sys_clk
    assign syncIn[SYNC_CTS]   = clearToSend;
    assign syncIn[SYNC_DSR]   = dataSetReady;
    assign syncIn[SYNC_DCD]   = carrierDetect;
    assign syncIn[SYNC_TXCLK] = dceTransmitClock;
    assign syncIn[SYNC_RXTOG] = rxTog_q;

    smh_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk    (sys_clk),
        .rstN   (nrst),
        .async  (syncIn),
        .synced (syncOut)
    );

    assign modem.cts = syncOut[SYNC_CTS];
    assign modem.dsr = syncOut[SYNC_DSR];
    assign modem.dcd = syncOut[SYNC_DCD];
    assign txClkS    = syncOut[SYNC_TXCLK];
    assign rxTogS    = syncOut[SYNC_RXTOG];

    // ---------------- receive, on the falling edge of the modem receive clock

    always_ff @(negedge dceReceiveClock)
    begin
        rxRstMeta_q <= nrst;
        rxRstN_q    <= rxRstMeta_q;
    end

    always_ff @(negedge dceReceiveClock)
    begin
        if (!rxRstN_q)
        begin
            dcdRxMeta_q <= 1'b0;
            dcdRx_q     <= 1'b0;
        end
        else
        begin
            dcdRxMeta_q <= carrierDetect;
            dcdRx_q     <= dcdRxMeta_q;
        end
    end

    // bit centre sampling, characters framed from carrier onset
    always_ff @(negedge dceReceiveClock)
    begin
        if (!rxRstN_q || !dcdRx_q)
        begin
            rxShift_q <= 8'h00;
            rxCnt_q   <= 4'h0;
        end
        else if (rxCnt_q == BITS_PER_CHAR - 4'h1)
        begin
            rxShift_q <= 8'h00;
            rxCnt_q   <= 4'h0;
        end
        else
        begin
            rxShift_q <= {serialRxIn, rxShift_q[BYTE_W-1:1]};
            rxCnt_q   <= rxCnt_q + 4'h1;
        end
    end

    // completed character held stable while the toggle crosses
    always_ff @(negedge dceReceiveClock)
    begin
        if (!rxRstN_q)
        begin
            rxByte_q <= 8'h00;
            rxTog_q  <= 1'b0;
        end
        else if (dcdRx_q && rxCnt_q == BITS_PER_CHAR - 4'h1)
        begin
            rxByte_q <= {serialRxIn, rxShift_q[BYTE_W-1:1]};
            rxTog_q  <= ~rxTog_q;
        end
    end

    // ---------------- system side of the receive path

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rxTogPrev_q <= 1'b0;
            rxValid     <= 1'b0;
            rxData      <= 8'h00;
        end
        else
        begin
            rxTogPrev_q <= rxTogS;
            rxValid     <= rxTogS ^ rxTogPrev_q;
            if (rxTogS ^ rxTogPrev_q)
            begin
                rxData <= rxByte_q;
            end
        end
    end

    // ---------------- transmit clocking

    assign localMode = syncMode & localClkSel;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            txClkPrev_q <= 1'b0;
        end
        else
        begin
            txClkPrev_q <= txClkS;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst || !localMode)
        begin
            divCnt_q <= 8'h00;
        end
        else if (divCnt_q == LOCAL_DIV - 8'h01)
        begin
            divCnt_q <= 8'h00;
        end
        else
        begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end

    // bit boundary: local divider wrap or rising modem transmit clock
    assign bitEdge = localMode ? (divCnt_q == 8'h00)
                               : (txClkS & ~txClkPrev_q);

    // high for the first half of the bit, falling at its centre
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            tclk_q <= 1'b0;
        end
        else if (localMode)
        begin
            tclk_q <= (divCnt_q < LOCAL_HALF);
        end
        else
        begin
            tclk_q <= txClkS;
        end
    end

    // ---------------- handshake control

    assign gate = rts_q & modem.cts & modem.dcd;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (dtr_q && sendRequest)
                begin
                    state_d = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (!dtr_q || !sendRequest)
                begin
                    state_d = ST_IDLE;
                end
                else if (modem.cts && modem.dcd)
                begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (!dtr_q)
                begin
                    state_d = ST_IDLE;
                end
                else if (!gate)
                begin
                    state_d = ST_REQ;
                end
                else if (!sendRequest)
                begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                if (!dtr_q)
                begin
                    state_d = ST_IDLE;
                end
                else if (bitEdge && gate && bitCnt_q == 4'h0)
                begin
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            rts_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rts_q   <= (state_d != ST_IDLE);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            dtr_q <= 1'b0;
        end
        else
        begin
            dtr_q <= terminalEnable;
        end
    end

    // ---------------- transmit data path

    // take only while ready is shown, so a held txValid is not taken again until the hold empties
    assign accept  = txValid & txReady;
    assign loadNow = bitEdge & gate & (state_q == ST_SEND)
                     & (bitCnt_q == 4'h0) & holdFull_q;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            hold_q     <= 8'h00;
            holdFull_q <= 1'b0;
        end
        else if (accept)
        begin
            hold_q     <= txData;
            holdFull_q <= 1'b1;
        end
        else if (loadNow)
        begin
            holdFull_q <= 1'b0;
        end
    end

    // bits leave only inside the gate; otherwise the line rests at mark
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            shift_q  <= 8'h00;
            bitCnt_q <= 4'h0;
            txd_q    <= LINE_MARK;
        end
        else if (!gate || !(state_q == ST_SEND || state_q == ST_DRAIN))
        begin
            txd_q <= LINE_MARK;
        end
        else if (bitEdge)
        begin
            if (loadNow)
            begin
                txd_q    <= hold_q[0];
                shift_q  <= {1'b0, hold_q[BYTE_W-1:1]};
                bitCnt_q <= BITS_PER_CHAR - 4'h1;
            end
            else if (bitCnt_q != 4'h0)
            begin
                txd_q    <= shift_q[0];
                shift_q  <= {1'b0, shift_q[BYTE_W-1:1]};
                bitCnt_q <= bitCnt_q - 4'h1;
            end
            else
            begin
                txd_q <= LINE_MARK;
            end
        end
    end

    // ---------------- registered outputs

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            txReady     <= 1'b0;
            modemReady  <= 1'b0;
            carrierOn   <= 1'b0;
            sendAllowed <= 1'b0;
        end
        else
        begin
            txReady     <= ~holdFull_q & ~accept;
            modemReady  <= modem.dsr;
            carrierOn   <= modem.dcd;
            sendAllowed <= gate & modem.dsr & dtr_q;
        end
    end

    assign serialTxOut      = txd_q;
    assign requestToSend    = rts_q;
    assign terminalReady    = dtr_q;
    assign terminalClockOut = tclk_q;

endmodule

//--- tb/smh_checker.sv
// concurrent checks on the serial port pins
`timescale 1ns/1ps
module smh_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic terminalEnable,
    input wire logic sendRequest,
    input wire logic syncMode,
    input wire logic localClkSel,
    input wire logic rxValid,
    input wire logic serialTxOut,
    input wire logic requestToSend,
    input wire logic clearToSend,
    input wire logic terminalReady,
    input wire logic dceTransmitClock,
    input wire logic terminalClockOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire localMode = syncMode && localClkSel;
    wire steady = terminalReady && clearToSend;
    property p_ctsGate; !clearToSend [*6] |-> serialTxOut; endproperty
    a_ctsGate: assert property (p_ctsGate) else $error("line busy without clear");
    property p_rtsRise; $rose(requestToSend) |-> $past(sendRequest) && $past(terminalReady);
    endproperty
    a_rtsRise: assert property (p_rtsRise) else $error("request rose uncommanded");
    property p_dtrOff; !terminalEnable [*2] |=> !terminalReady && !requestToSend; endproperty
    a_dtrOff: assert property (p_dtrOff) else $error("terminal ready not dropped");
    property p_echoBit; $changed(serialTxOut) && !localMode && steady && $past(clearToSend, 8)
        |-> $past(dceTransmitClock, 2) && !$past(dceTransmitClock, 6); endproperty
    a_echoBit: assert property (p_echoBit) else $error("bit change off clock rise");
    property p_localBit; $changed(serialTxOut) && localMode && steady && $past(clearToSend, 8)
        |-> $rose(terminalClockOut); endproperty
    a_localBit: assert property (p_localBit) else $error("bit change off local rise");
    property p_localClk; localMode && $rose(terminalClockOut)
        |-> terminalClockOut [*8] ##1 !terminalClockOut; endproperty
    a_localClk: assert property (p_localClk) else $error("local clock shape wrong");
    property p_echoClk; !localMode && $rose(terminalClockOut)
        |-> $past(dceTransmitClock, 2) && !$past(dceTransmitClock, 6); endproperty
    a_echoClk: assert property (p_echoClk) else $error("terminal clock not echoed");
    property p_rxPulse; rxValid |=> !rxValid; endproperty
    a_rxPulse: assert property (p_rxPulse) else $error("receive pulse too long");
endmodule
bind smh_serial_port smh_checker uChecker (
    .sys_clk, .nrst, .terminalEnable, .sendRequest, .syncMode, .localClkSel, .rxValid,
    .serialTxOut, .requestToSend, .clearToSend, .terminalReady, .dceTransmitClock,
    .terminalClockOut
);

//--- tb/smh_modem_model.sv
// modem side model: handshake replies, link clocks, data capture
`timescale 1ns/1ps
module smh_modem_model (
    input  wire logic sys_clk,
    input  wire logic slow,
    input  wire logic carrierWanted,
    input  wire logic requestToSend,
    input  wire logic terminalReady,
    input  wire logic serialTxOut,
    input  wire logic terminalClockOut,
    output logic      clearToSend,
    output logic      dataSetReady,
    output logic      carrierDetect,
    output logic      dceTransmitClock,
    output logic      dceReceiveClock,
    output logic      serialRxIn
);
    int   rtsCnt = 0;
    logic txBits[$];
    always @(posedge sys_clk)
    begin
        rtsCnt <= requestToSend ? rtsCnt + 1 : 0;
        dataSetReady <= terminalReady;
    end
    assign clearToSend = requestToSend && (rtsCnt > (slow ? 40 : 2));
    assign carrierDetect = carrierWanted;
    // clock runs only while transmit is requested
    initial
    begin
        dceTransmitClock = 1'b0;
        #13;
        forever
        begin
            #400;
            dceTransmitClock = requestToSend & ~dceTransmitClock;
        end
    end
    always @(negedge terminalClockOut)
        if (requestToSend && clearToSend && carrierDetect && dataSetReady && terminalReady)
            txBits.push_back(serialTxOut);
    task automatic rxFrame(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            dceReceiveClock = 1'b1;
            serialRxIn = b[i];
            #3 dceReceiveClock = 1'b0;
            #3;
        end
        serialRxIn = ~serialRxIn;
    endtask
endmodule

//--- tb/smh_serial_port_tb_top.sv
// self-checking bench for the serial port modem handshake block
`timescale 1ns/1ps
module smh_serial_port_tb_top
    import smh_pkg::*;
;
    logic              sys_clk, nrst, txValid, terminalEnable, sendRequest, syncMode;
    logic              localClkSel, slow, carrierWanted, txReady, rxValid, modemReady;
    logic              carrierOn, sendAllowed, serialTxOut, serialRxIn, requestToSend;
    logic              clearToSend, dataSetReady, carrierDetect, terminalReady;
    logic              dceTransmitClock, dceReceiveClock, terminalClockOut;
    logic [BYTE_W-1:0] txData, rxData, b;
    logic [BYTE_W-1:0] sent[$];
    logic [31:0]       seed;
    int                mismatches = 0;
    int                totalChecks = 0;
    smh_serial_port dut (.sys_clk, .nrst, .txValid, .txData, .txReady, .rxValid, .rxData,
        .terminalEnable, .sendRequest, .syncMode, .localClkSel, .modemReady, .carrierOn,
        .sendAllowed, .serialTxOut, .serialRxIn, .requestToSend, .clearToSend, .dataSetReady,
        .carrierDetect, .terminalReady, .dceTransmitClock, .dceReceiveClock, .terminalClockOut);
    smh_modem_model modem (.sys_clk, .slow, .carrierWanted, .requestToSend, .terminalReady,
        .serialTxOut, .terminalClockOut, .clearToSend, .dataSetReady, .carrierDetect,
        .dceTransmitClock, .dceReceiveClock, .serialRxIn);
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // line order is lsb first
    function automatic logic expBit(input int k);
        return sent[k / 8][k % 8];
    endfunction
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic waitFor(input int which, input logic val);
        int n;
        n = 0;
        while (n < 3000 && (which == 0 ? txReady : which == 1 ? rxValid : requestToSend) !== val)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 3000)
        begin
            mismatches++;
            wrapUp();
        end
    endtask
    task automatic doReset(input logic s, input logic l);
        nrst = 1'b0;
        syncMode = s;
        localClkSel = l;
        fork
            repeat (12) @(negedge sys_clk);
            modem.rxFrame(8'h00, 4);
        join
        chk("idle line", 8'h01, 8'(serialTxOut));
        chk("rts in reset", 8'h00, 8'(requestToSend));
        nrst = 1'b1;
    endtask
    task automatic putByte(input logic [7:0] v);
        sent.push_back(v);
        txData = v;
        txValid = 1'b1;
        waitFor(0, 1'b1);
        @(negedge sys_clk);
        txValid = 1'b0;
        @(negedge sys_clk);
    endtask
    initial
    begin
        {txValid, sendRequest, slow, carrierWanted} = 4'h0;
        terminalEnable = 1'b1;
        txData = 8'h00;
        seed = 32'h0000_a0a6;
        doReset(1'b0, 1'b0);
        carrierWanted = 1'b1;
        modem.rxFrame(8'h00, 4);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsrNext(seed);
            b = i == 0 ? 8'hff : i == 1 ? 8'h00 : seed[7:0];
            modem.rxFrame(b, 8);
            waitFor(1, 1'b1);
            chk("rxData", b, rxData);
            repeat (2) @(negedge sys_clk);
        end
        chk("carrierOn", 8'h01, 8'(carrierOn));
        chk("modemReady", 8'h01, 8'(modemReady));
        for (int m = 0; m < 3; m++)
        begin
            doReset(m != 0, m != 1);
            slow = m == 0;
            sent.delete();
            modem.txBits.delete();
            sendRequest = 1'b1;
            for (int i = 0; i < 4; i++)
            begin
                seed = lfsrNext(seed);
                b = i == 0 ? 8'h00 : i == 3 ? 8'hfe : seed[7:0] & 8'hfe;
                putByte(b);
                if (i == 0 && slow)
                    repeat (30)
                    begin
                        @(negedge sys_clk);
                        chk("line while not clear", 8'h01, 8'(serialTxOut));
                    end
            end
            waitFor(0, 1'b1);
            chk("sendAllowed", 8'h01, 8'(sendAllowed));
            sendRequest = 1'b0;
            waitFor(2, 1'b0);
            while (modem.txBits.size() > 0 && modem.txBits[0] === 1'b1)
                void'(modem.txBits.pop_front());
            chk("bit count", 8'h20, 8'(modem.txBits.size()));
            for (int k = 0; k < 32; k++)
                chk("line bit", 8'(expBit(k)), 8'(modem.txBits[k]));
        end
        sendRequest = 1'b1;
        waitFor(2, 1'b1);
        terminalEnable = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("rts after abort", 8'h00, 8'(requestToSend));
        chk("modemReady off", 8'h00, 8'(modemReady));
        chk("sendAllowed off", 8'h00, 8'(sendAllowed));
        wrapUp();
    end
endmodule
